/* File: timer_prescaler_defines.svh */
// constants of the timer/counter with shared prescaler
// assumes one clock domain and four clock phases per instruction cycle
//
// Notes on behaviour
// RULE_01: count source select clear: counter steps every instruction cycle, no prescaler.
// RULE_02: a count register write stops increments for the two following instruction cycles.
// RULE_03: count source select set: counter steps on edges of the external pin.
// RULE_04: source edge select clear counts rising edges, set counts falling edges.
// RULE_05: assign bit clear gives prescaler to counter, set to watchdog; never both.
// RULE_06: for the counter, three ratio bits pick 1:2 up to 1:256 in powers of two.
// RULE_07: prescaler is an 8-bit counter, neither readable nor writable by software.
// RULE_08: with prescaler on counter, every count register write also clears the prescaler.
// RULE_09: with prescaler on watchdog, the watchdog clear instruction clears the prescaler.
// RULE_10: any reset loads the prescaler with all zeros.
// RULE_11: external path sampled from the prescaler output on phases two and four.
// RULE_12: without prescaler the pin stays high and low two periods plus 20 ns.
// RULE_13: with prescaler pin period four periods plus 40 ns over ratio; pulses 10 ns.
// RULE_14: external input divided by the prescaler so its output is symmetrical.
// RULE_15: external increment lands a short synchronisation delay after the pin edge.
// RULE_16: software sequence for moving the prescaler from counter to watchdog.
// RULE_17: software sequence for moving the prescaler from watchdog to counter.
// RULE_18: counter rolls from FF to 00 and keeps counting.
`ifndef TIMER_PRESCALER_DEFINES_SVH
`define TIMER_PRESCALER_DEFINES_SVH

`define TCP_ADDR_W 8
`define TCP_DATA_W 8
`define TCP_ADDR_OPTION 8'h00
`define TCP_ADDR_TIMER 8'h01
`define TCP_OPTION_RESET 8'hFF
`define TCP_TIMER_RESET 8'h00
`define TCP_BIT_COUNT_SOURCE 5
`define TCP_BIT_EDGE_SELECT 4
`define TCP_BIT_PRESCALER_ASSIGN 3
`define TCP_RATIO_MSB 2
`define TCP_RATIO_LSB 0
`define TCP_PRESCALER_W 8
`define TCP_PRESCALER_RESET 8'h00
`define TCP_INHIBIT_CYCLES 2'h2
`define TCP_READ_IDLE 8'h00

`endif

/* File: timer_prescaler_pkg.sv */
// types used by the timer/counter top, not by the prescaler core
// assumes the defines header is compiled alongside
package timer_prescaler_pkg;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

    typedef struct packed {
        logic [1:0] portBits;
        logic countSource;
        logic edgeSelect;
        logic prescalerAssign;
        logic [2:0] prescaleRatio;
    } option_t;

endpackage : timer_prescaler_pkg

/* File: prescaler_if.sv */
// carrier between the timer top and the shared prescaler
// assumes both ends run on sys_clk
`timescale 1ns/10ps
interface prescaler_if;
    logic countEvent;
    logic clear;
    logic [2:0] ratio;
    logic [7:0] value;
    logic [7:0] allOnes;

    modport owner (output countEvent, output clear, output ratio, input value, input allOnes);
    modport core (input countEvent, input clear, input ratio, output value, output allOnes);
endinterface : prescaler_if

/* File: pin_sync.sv */
// three stage synchroniser for one pin, with an agree filter
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/10ps
module pin_sync (
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic pinIn, // raw pin level
    output logic level // filtered level
);
    logic stage1, stage2, stage3;
    logic next_level;

    // level moves only once the second and third stages agree
    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule : pin_sync

/* File: prescaler_core.sv */
// shared 8-bit prescaler / postscaler counter
// assumes the owner gives one-cycle count events and clear pulses
`timescale 1ns/10ps
`include "timer_prescaler_defines.svh"
module prescaler_core #(
    parameter int WIDTH = `TCP_PRESCALER_W // counter width
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous, active high
    prescaler_if.core pif // events, clear and taps
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // prefix and of the low bits, one tap per ratio
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_tap
            assign pif.allOnes[i] = &count[i:0];
        end
    endgenerate

    assign pif.value = count;

    always_comb begin
        next_count = count;
        if (pif.clear) begin
            next_count = `TCP_PRESCALER_RESET; // [RULE_08] [RULE_09]
        end else if (pif.countEvent) begin
            next_count = count + 1'b1; // [RULE_07]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= `TCP_PRESCALER_RESET; // [RULE_10]
        end else begin
            count <= next_count;
        end
    end
endmodule : prescaler_core

/* File: timer_counter_prescaler.sv */
// top of the 8-bit timer/counter with shared prescaler
// assumes a plain register port, a same-clock watchdog time base,
// and a watchdog clear pulse from the instruction decoder
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "timer_prescaler_defines.svh"
module timer_counter_prescaler
    import timer_prescaler_pkg::*;
(
    input wire logic sys_clk, // system clock, 25 MHz
    input wire logic reset, // synchronous, active high
    input wire logic [7:0] regAddr, // register address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdData, // read data, cycle after strobe
    input wire logic extCountInput, // external count pin
    input wire logic watchdogClearInstr, // watchdog clear pulse
    input wire logic watchdogTick, // raw watchdog time base pulse
    output logic watchdogOut, // watchdog time base after postscaler
    output logic [1:0] portControl // upper option bits for port logic
);

    // ************************************************************
    // state
    // ************************************************************
    phase_t phase, next_phase;
    option_t option, next_option;
    logic [7:0] timerCount, next_timerCount;
    logic [1:0] inhibitCount, next_inhibitCount;
    logic rawPrev, next_rawPrev;
    logic sampled, next_sampled;
    logic [7:0] next_regRdData;
    logic next_watchdogOut;

    logic syncLevel;
    logic rawSelLevel;
    logic rawSelEdge;
    logic instrEnd;
    logic samplePhase;
    logic srcLevel;
    logic extIncrement;
    logic timerWrite;
    logic optionWrite;
    logic prescOnTimer;
    logic prescCarryTimer;
    logic prescCarryWatchdog;
    logic incrementRequest;

    prescaler_if pif ();

    // ************************************************************
    // submodules
    // ************************************************************
    pin_sync u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(extCountInput),
        .level(syncLevel)
    );

    prescaler_core #(
        .WIDTH(`TCP_PRESCALER_W)
    ) u_prescaler (
        .sys_clk(sys_clk),
        .reset(reset),
        .pif(pif)
    );

    // ************************************************************
    // decode
    // ************************************************************
    assign timerWrite = regWr && (regAddr == `TCP_ADDR_TIMER);
    assign optionWrite = regWr && (regAddr == `TCP_ADDR_OPTION);
    assign instrEnd = (phase == PH_Q4);
    assign samplePhase = (phase == PH_Q2) || (phase == PH_Q4); // [RULE_11]
    assign prescOnTimer = !option.prescalerAssign; // [RULE_05]

    // edge select folds the counted edge into a rising one
    assign rawSelLevel = syncLevel ^ option.edgeSelect; // [RULE_04]
    assign rawSelEdge = rawSelLevel && !rawPrev;

    // ************************************************************
    // prescaler steering
    // ************************************************************
    always_comb begin
        pif.ratio = option.prescaleRatio;
        pif.countEvent = 1'b0;
        pif.clear = 1'b0;
        if (prescOnTimer) begin
            // counter owns the prescaler, watchdog runs undivided
            if (option.countSource) begin
                pif.countEvent = rawSelEdge; // [RULE_14]
            end else begin
                pif.countEvent = instrEnd;
            end
            pif.clear = timerWrite; // [RULE_08]
        end else begin
            pif.countEvent = watchdogTick;
            pif.clear = watchdogClearInstr; // [RULE_09]
        end
    end

    // counter taps: 1:2 for ratio 0 up to 1:256 for ratio 7
    assign prescCarryTimer = pif.countEvent && pif.allOnes[option.prescaleRatio]; // [RULE_06]

    // watchdog taps: 1:1 for ratio 0 up to 1:128 for ratio 7
    always_comb begin
        prescCarryWatchdog = watchdogTick;
        if (option.prescaleRatio != 3'h0) begin
            prescCarryWatchdog = watchdogTick && pif.allOnes[option.prescaleRatio - 3'h1];
        end
    end

    // ************************************************************
    // external path sampling
    // ************************************************************
    // divided output is a square wave; undivided it is the synchronised pin level after edge select
    always_comb begin
        srcLevel = rawSelLevel;
        if (prescOnTimer) begin
            srcLevel = pif.value[option.prescaleRatio]; // [RULE_14]
        end
    end

    // a rise seen at a sample point gives the increment
    assign extIncrement = samplePhase && srcLevel && !sampled; // [RULE_11] [RULE_15]

    always_comb begin
        next_sampled = sampled;
        next_rawPrev = rawSelLevel;
        if (samplePhase) begin
            next_sampled = srcLevel; // [RULE_11]
        end
    end

    // ************************************************************
    // instruction phases
    // ************************************************************
    always_comb begin
        unique case (phase)
            PH_Q1: next_phase = PH_Q2;
            PH_Q2: next_phase = PH_Q3;
            PH_Q3: next_phase = PH_Q4;
            PH_Q4: next_phase = PH_Q1;
        endcase
    end

    // ************************************************************
    // increment source
    // ************************************************************
    always_comb begin
        incrementRequest = 1'b0;
        if (option.countSource) begin
            incrementRequest = extIncrement; // [RULE_03] [RULE_15]
        end else if (prescOnTimer) begin
            incrementRequest = prescCarryTimer; // [RULE_06]
        end else begin
            incrementRequest = instrEnd; // [RULE_01]
        end
    end

    // ************************************************************
    // timer count and inhibit window
    // ************************************************************
    always_comb begin
        next_timerCount = timerCount;
        next_inhibitCount = inhibitCount;
        if (timerWrite) begin
            next_timerCount = regWrData;
            next_inhibitCount = `TCP_INHIBIT_CYCLES; // [RULE_02]
        end else begin
            if (incrementRequest && (inhibitCount == 2'h0)) begin
                next_timerCount = timerCount + 8'h01; // [RULE_18]
            end
            if (instrEnd && (inhibitCount != 2'h0)) begin
                next_inhibitCount = inhibitCount - 2'h1; // [RULE_02]
            end
        end
    end

    // ************************************************************
    // option control
    // ************************************************************
    // software orders assignment moves so the watchdog sees no glitch
    always_comb begin
        next_option = option;
        if (optionWrite) begin
            next_option = option_t'(regWrData); // [RULE_16] [RULE_17]
        end
    end

    // ************************************************************
    // register reads and watchdog output
    // ************************************************************
    always_comb begin
        next_regRdData = `TCP_READ_IDLE;
        if (regRd && (regAddr == `TCP_ADDR_TIMER)) begin
            next_regRdData = timerCount;
        end
    end

    always_comb begin
        next_watchdogOut = watchdogTick;
        if (!prescOnTimer) begin
            next_watchdogOut = prescCarryWatchdog; // [RULE_05]
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase <= PH_Q1;
            option <= option_t'(`TCP_OPTION_RESET);
            timerCount <= `TCP_TIMER_RESET;
            inhibitCount <= 2'h0;
            // idle selected level after reset is high: falling edge, pin low
            rawPrev <= 1'b1;
            sampled <= 1'b1;
            regRdData <= `TCP_READ_IDLE;
            watchdogOut <= 1'b0;
            portControl <= 2'h3;
        end else begin
            phase <= next_phase;
            option <= next_option;
            timerCount <= next_timerCount;
            inhibitCount <= next_inhibitCount;
            rawPrev <= next_rawPrev;
            sampled <= next_sampled;
            regRdData <= next_regRdData;
            watchdogOut <= next_watchdogOut;
            portControl <= next_option.portBits;
        end
    end

endmodule : timer_counter_prescaler

/* File: ext_pulse_src.sv */
// count pin source: toggles the pin a given number of times
// assumes a request only while the previous burst is over
`timescale 1ns/10ps
module ext_pulse_src (
    input wire logic sys_clk, // clock
    input wire logic go, // start burst
    input wire logic [3:0] toggles, // edges to make
    output logic pin // count pin
);
    int left = 0;
    int hold = 0;
    initial pin = 1'b0;
    // each level held 4 cycles, 160 ns
    always @(posedge sys_clk) begin
        if (go) begin
            left <= int'(toggles);
            hold <= 4;
        end else if (left != 0 && hold == 1) begin
            pin <= ~pin;
            left <= left - 1;
            hold <= 4;
        end else if (left != 0) begin
            hold <= hold - 1;
        end
    end
endmodule : ext_pulse_src

/* File: timer_counter_prescaler_properties.sv */
// checker on the top ports of the timer/counter
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
module timer_counter_prescaler_properties (
    input wire logic sys_clk, // clock
    input wire logic reset, // reset
    input wire logic [7:0] regAddr, // address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [7:0] regRdData, // read data
    input wire logic extCountInput, // count pin
    input wire logic watchdogClearInstr, // clear pulse
    input wire logic watchdogTick, // tick in
    input wire logic watchdogOut, // tick out
    input wire logic [1:0] portControl // port bits
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ****
    // option shadow and timer mode reference
    // ****
    logic [7:0] opt, next_opt, tm, next_tm;
    logic [1:0] ph, next_ph, inh, next_inh;
    logic ok, next_ok;
    wire optWr = regWr && regAddr == 8'h00;
    wire tmWr = regWr && regAddr == 8'h01;
    wire rdTm = regRd && regAddr == 8'h01;
    wire rdOther = regRd && regAddr != 8'h01;
    always_comb begin
        next_opt = optWr ? regWrData : opt;
        next_ph = ph + 2'h1;
        next_ok = ok && !optWr;
        next_tm = tm;
        next_inh = inh;
        if (tmWr) begin
            next_ok = !opt[5] && opt[3];
            next_tm = regWrData;
            next_inh = 2'h2;
        end else if (ph == 2'h3 && inh != 2'h0) begin
            next_inh = inh - 2'h1;
        end else if (ph == 2'h3) begin
            next_tm = tm + 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            opt <= 8'hFF;
            ph <= 2'h0;
            ok <= 1'b0;
        end else begin
            opt <= next_opt;
            ph <= next_ph;
            ok <= next_ok;
        end
        tm <= next_tm;
        inh <= next_inh;
    end
    // ****
    // port relations
    // ****
    a_read_idle_zero:
        assert property (!$past(regRd) |-> regRdData == 8'h00) else $error("stray read data");
    a_option_unread:
        assert property ($past(rdOther) |-> regRdData == 8'h00) else $error("option readable");
    a_timer_ref:
        assert property ($past(rdTm) && $past(ok) |-> regRdData == $past(tm))
        else $error("timer differs from reference");
    a_write_read:
        assert property (tmWr ##1 rdTm |=> regRdData == $past(regWrData, 2))
        else $error("written count lost");
    a_wdog_bypass:
        assert property (!opt[3] |=> watchdogOut == $past(watchdogTick))
        else $error("tick not passed through");
    a_wdog_direct:
        assert property (opt[3] && opt[2:0] == 3'h0 |=> watchdogOut == $past(watchdogTick))
        else $error("one to one tick lost");
    a_wdog_no_stray:
        assert property (!watchdogTick |=> !watchdogOut) else $error("tick out without tick");
    a_port_bits:
        assert property (portControl == opt[7:6]) else $error("port bits wrong");
endmodule : timer_counter_prescaler_properties

bind timer_counter_prescaler timer_counter_prescaler_properties props_u (.sys_clk, .reset,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .extCountInput, .watchdogClearInstr,
    .watchdogTick, .watchdogOut, .portControl);

/* File: test_timer_counter_prescaler.sv */
// bench for the timer/counter with shared prescaler
// assumes the pin source model and the bound checker
`timescale 1ns/10ps
module test_timer_counter_prescaler;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic pin;
    logic go = 1'b0;
    logic [3:0] toggles = 4'h0;
    logic wdClr = 1'b0;
    logic wdTick = 1'b0;
    logic wdOut;
    logic [1:0] portControl;
    logic [7:0] rv;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int outs = 0;
    timer_counter_prescaler dut_u (.sys_clk, .reset, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .extCountInput(pin), .watchdogClearInstr(wdClr), .watchdogTick(wdTick),
        .watchdogOut(wdOut), .portControl);
    ext_pulse_src src_u (.sys_clk, .go, .toggles, .pin);
    initial forever #20 sys_clk = ~sys_clk;
    // cycle index gives the phase, Q4 when index mod 4 is 3
    always @(posedge sys_clk) begin
        cyc <= reset ? 0 : cyc + 1;
        outs <= outs + int'(wdOut === 1'b1);
    end
    // ****
    // bus and helper tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        idle(1);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        idle(1);
        regRd <= 1'b0;
        rv = regRdData;
    endtask : rd
    task automatic align;
        for (int i = 0; i < 4 && cyc % 4 != 3; i++) idle(1);
    endtask : align
    task automatic wd(input logic clr);
        if (clr) wdClr <= 1'b1;
        else wdTick <= 1'b1;
        idle(1);
        wdClr <= 1'b0;
        wdTick <= 1'b0;
        idle(2);
    endtask : wd
    task automatic cnt(input logic [7:0] o, input logic [3:0] n, input logic [7:0] e);
        wr(8'h00, o);
        wr(8'h01, 8'h00);
        idle(12);
        toggles <= n;
        go <= 1'b1;
        idle(1);
        go <= 1'b0;
        idle(4 * n + 16);
        rd(8'h01);
        check(rv, e);
    endtask : cnt
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        check({6'h00, portControl}, 8'h03);
        wr(8'h05, 8'h55);
        rd(8'h01);
        check(rv, 8'h00);
        rd(8'h00);
        check(rv, 8'h00);
        rd(8'h05);
        check(rv, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_timer;
        wr(8'h00, 8'h08);
        check({6'h00, portControl}, 8'h00);
        align();
        wr(8'h01, 8'hFE);
        rd(8'h01);
        check(rv, 8'hFE);
        idle(10);
        rd(8'h01);
        check(rv, 8'hFE);
        rd(8'h01);
        check(rv, 8'hFF);
        idle(3);
        rd(8'h01);
        check(rv, 8'h00);
        $display("timer test done");
    endtask : t_timer
    task automatic t_count;
        cnt(8'hE8, 4'h5, 8'h03);
        cnt(8'hF8, 4'h5, 8'h03);
        wd(1'b1);
        cnt(8'hE0, 4'h8, 8'h02);
        $display("count test done");
    endtask : t_count
    task automatic t_prescale;
        logic [7:0] d;
        wd(1'b1);
        for (int r = 0; r < 8; r++) begin
            wr(8'h00, 8'hC0 | 8'(r));
            idle(12);
            rd(8'h01);
            d = rv;
            idle((8 << r) - 1);
            rd(8'h01);
            check(rv - d, 8'h01);
        end
        wr(8'h00, 8'hC1);
        align();
        wr(8'h01, 8'h00);
        idle(15);
        rd(8'h01);
        check(rv, 8'h00);
        rd(8'h01);
        check(rv, 8'h01);
        $display("prescale test done");
    endtask : t_prescale
    task automatic t_wdog;
        int n;
        wd(1'b1);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'hCF);
        wd(1'b1);
        wr(8'h00, 8'hC9);
        n = outs;
        for (int i = 5; i >= 0; i--) wd(i == 5 || i == 3);
        check(8'(outs - n), 8'h01);
        wr(8'h00, 8'hC8);
        n = outs;
        wd(1'b0);
        check(8'(outs - n), 8'h01);
        $display("watchdog test done");
    endtask : t_wdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
    initial begin
        idle(2);
        reset <= 1'b0;
        t_reset();
        t_timer();
        t_count();
        t_prescale();
        t_wdog();
        end_sim();
    end
endmodule : test_timer_counter_prescaler
